// >>> hw/btl_pkg.sv
//
// Notes on behaviour
// - With the coaxial trigger enabled as a break condition, every new rising edge on it is a break event and is latched.
// - A latched break event is reported on the first status read after it, in or out of the monitor.
// - Enabling the coordination trigger while its line is true reports at once and breaks unless in the monitor.
// - The coordination trigger event is reported once per break, monitor or run cycle even if the line stays true.
// - A coordination trigger still true after a run request, already reported in the monitor, breaks straight back.
// - Enabling a trigger line first clears its old latched events, then reports and breaks at once if it is true.
// - A trigger line held true by a lasting coordination trigger reports once per break, monitor or run cycle.
// - A trigger line driven internally, or after the coordination trigger drops, reports on every read while true.
// - Trigger line two behaves exactly like trigger line one.
// - On the execute pulse the enabled analyzers start their traces and each start is latched as an event.
// - On the execute pulse an enabled emulator starts the user program and the start is latched as an event.
// - If the program cannot start on the execute pulse a run-failure error is latched.
// - If an analyzer cannot load its trace setup on the execute pulse a trace error is latched.
// - A setup where one analyzer both drives and receives the same trigger line is refused with an error.
package btl_pkg;
    localparam int BTL_AW = 8;
    localparam int BTL_DW = 32;
    // --------------------------------------------------
    // Register offsets
    // --------------------------------------------------
    localparam logic [BTL_AW-1:0] BTL_CTRL = 8'h00;
    localparam logic [BTL_AW-1:0] BTL_ROUTE = 8'h04;
    localparam logic [BTL_AW-1:0] BTL_STATUS = 8'h08;
    localparam logic [BTL_AW-1:0] BTL_MASK = 8'h0c;
    localparam logic [BTL_AW-1:0] BTL_STATE = 8'h10;
    // --------------------------------------------------
    // Control fields
    // --------------------------------------------------
    localparam int CTL_COAX = 0;
    localparam int CTL_COORD = 1;
    localparam int CTL_ONE = 2;
    localparam int CTL_TRACE = 4;
    localparam int CTL_XTRACE = 5;
    localparam int CTL_RUN = 6;
    localparam int CTL_W = 7;
    localparam logic [CTL_W-1:0] CTL_RST = 7'h00;
    // --------------------------------------------------
    // Route fields, one group per trigger line
    // --------------------------------------------------
    localparam int RT_EMU_DRV = 0;
    localparam int RT_EMU_RCV = 1;
    localparam int RT_EXT_DRV = 2;
    localparam int RT_EXT_RCV = 3;
    localparam int RT_COORD = 4;
    localparam int RT_LINE_W = 5;
    localparam int RT_W = 10;
    localparam logic [RT_W-1:0] RT_RST = 10'h000;
    // --------------------------------------------------
    // Status fields
    // --------------------------------------------------
    localparam int ST_COAX = 0;
    localparam int ST_COORD = 1;
    localparam int ST_ONE = 2;
    localparam int ST_TWO = 3;
    localparam int ST_TRACE = 4;
    localparam int ST_XTRACE = 5;
    localparam int ST_RUN = 6;
    localparam int ST_RUNFAIL = 7;
    localparam int ST_TRERR = 8;
    localparam int ST_CONF = 9;
    localparam int ST_W = 11;
    localparam logic [ST_W-1:0] ST_RST = 11'h000;
    localparam logic [ST_W-1:0] MASK_RST = 11'h000;
    // --------------------------------------------------
    // Pin vector positions
    // --------------------------------------------------
    localparam int PIN_COAX = 0;
    localparam int PIN_COORD = 1;
    localparam int PIN_EXEC = 2;
    localparam int PIN_ONE = 3;
    localparam int PIN_W = 5;
endpackage

// >>> hw/btl_sync.sv
`timescale 1ns/100ps
module btl_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Pins
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    if (WIDTH < 1) begin : g_chk
        $error("btl_sync needs WIDTH of at least 1");
    end
    logic [WIDTH-1:0] meta;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            syncOut <= '0;
        end else begin
            meta <= asyncIn;
            syncOut <= meta;
        end
    end
endmodule // btl_sync

// >>> hw/btl_break_trigger.sv
`timescale 1ns/100ps
module btl_break_trigger (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [btl_pkg::BTL_AW-1:0] regAddr,
    input wire logic [btl_pkg::BTL_DW-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [btl_pkg::BTL_DW-1:0] regRdData,
    // Trigger pins
    input wire logic coaxialTriggerConnector,
    input wire logic coordTrigger,
    input wire logic coordExecute,
    input wire logic internalTriggerOne,
    input wire logic internalTriggerTwo,
    // Emulator core, same clock
    input wire logic monitorActive,
    input wire logic runBlocked,
    input wire logic traceSetupBad,
    input wire logic extTraceSetupBad,
    // Requests to the core
    output logic breakReq,
    output logic traceStart,
    output logic extTraceStart,
    output logic runStart,
    // Interrupt
    output logic irq
);
    import btl_pkg::*;

    typedef struct packed {
        logic [CTL_W-1:0] ctrl;
        logic [RT_W-1:0] route;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic sentCoord;
        logic [1:0] sentLine;
        logic monPrev;
        logic coaxPrev;
        logic execPrev;
        logic breakReq;
        logic traceStart;
        logic extTraceStart;
        logic runStart;
        logic irq;
        logic [BTL_DW-1:0] rdData;
    } btl_state_t;

    btl_state_t st;
    btl_state_t next_st;
    logic [PIN_W-1:0] pinS;
    logic coaxS;
    logic coordS;
    logic execS;
    logic [1:0] lineS;
    logic rdStat;
    logic execRise;

    function automatic logic routeClash(input logic [RT_LINE_W-1:0] f);
        return (f[RT_EMU_DRV] & f[RT_EMU_RCV]) | (f[RT_EXT_DRV] & f[RT_EXT_RCV]);
    endfunction

    // --------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------
    btl_sync #(.WIDTH(PIN_W)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .asyncIn({internalTriggerTwo, internalTriggerOne, coordExecute, coordTrigger, coaxialTriggerConnector}),
        .syncOut(pinS)
    );

    assign coaxS = pinS[PIN_COAX];
    assign coordS = pinS[PIN_COORD];
    assign execS = pinS[PIN_EXEC];
    assign lineS = pinS[PIN_ONE +: 2];
    assign rdStat = regRd && (regAddr == BTL_STATUS);
    assign execRise = execS && !st.execPrev;

    // --------------------------------------------------
    // Next state
    // --------------------------------------------------
    always_comb begin
        logic [ST_W-1:0] setEv;
        logic [ST_W-1:0] clrEv;
        logic [1:0] lineOnce;
        logic [1:0] enRise;
        logic coordRise;
        logic trig;
        logic cycleEdge;
        setEv = '0;
        clrEv = '0;
        lineOnce = '0;
        enRise = '0;
        coordRise = 1'b0;
        trig = 1'b0;
        cycleEdge = monitorActive != st.monPrev;
        next_st = st;
        next_st.monPrev = monitorActive;
        next_st.coaxPrev = coaxS;
        next_st.execPrev = execS;
        next_st.traceStart = 1'b0;
        next_st.extTraceStart = 1'b0;
        next_st.runStart = 1'b0;
        next_st.rdData = '0;
        // Register reads
        if (regRd) begin
            case (regAddr)
                BTL_CTRL: next_st.rdData = BTL_DW'(st.ctrl);
                BTL_ROUTE: next_st.rdData = BTL_DW'(st.route);
                BTL_STATUS: next_st.rdData = BTL_DW'(st.status);
                BTL_MASK: next_st.rdData = BTL_DW'(st.mask);
                BTL_STATE: next_st.rdData = BTL_DW'({st.breakReq, lineS, coordS, coaxS, monitorActive});
                default: next_st.rdData = '0;
            endcase
        end
        if (rdStat) begin
            clrEv = st.status;
        end
        // Register writes
        if (regWr) begin
            case (regAddr)
                BTL_CTRL: begin
                    next_st.ctrl = regWrData[CTL_W-1:0];
                    enRise = regWrData[CTL_ONE +: 2] & ~st.ctrl[CTL_ONE +: 2];
                    coordRise = regWrData[CTL_COORD] & ~st.ctrl[CTL_COORD];
                end
                BTL_ROUTE: begin
                    for (int k = 0; k < 2; k++) begin
                        if (routeClash(regWrData[k*RT_LINE_W +: RT_LINE_W])) begin
                            setEv[ST_CONF + k] = 1'b1;
                        end else begin
                            next_st.route[k*RT_LINE_W +: RT_LINE_W] = regWrData[k*RT_LINE_W +: RT_LINE_W];
                        end
                    end
                end
                BTL_MASK: next_st.mask = regWrData[ST_W-1:0];
                default: ;
            endcase
        end
        // Coaxial trigger, edge sensitive
        if (st.ctrl[CTL_COAX] && coaxS && !st.coaxPrev) begin
            setEv[ST_COAX] = 1'b1;
            trig = 1'b1;
        end
        // Coordination trigger, level sensitive, once per cycle
        if (st.ctrl[CTL_COORD] && coordS) begin
            trig = 1'b1;
            if (!st.sentCoord && !(rdStat && st.status[ST_COORD])) begin
                setEv[ST_COORD] = 1'b1;
            end
        end
        if (cycleEdge || coordRise) begin
            next_st.sentCoord = 1'b0;
        end else if (rdStat && st.status[ST_COORD]) begin
            next_st.sentCoord = 1'b1;
        end
        if (coordRise) begin
            clrEv[ST_COORD] = 1'b1;
        end
        // Internal trigger lines one and two
        for (int k = 0; k < 2; k++) begin
            lineOnce[k] = st.route[k*RT_LINE_W + RT_COORD] && coordS;
            if (st.ctrl[CTL_ONE + k] && lineS[k]) begin
                trig = 1'b1;
                if (!(lineOnce[k] && (st.sentLine[k] || (rdStat && st.status[ST_ONE + k])))) begin
                    setEv[ST_ONE + k] = 1'b1;
                end
            end
            if (cycleEdge || enRise[k] || !lineOnce[k]) begin
                next_st.sentLine[k] = 1'b0;
            end else if (rdStat && st.status[ST_ONE + k]) begin
                next_st.sentLine[k] = 1'b1;
            end
            if (enRise[k]) begin
                clrEv[ST_ONE + k] = 1'b1;
            end
        end
        // Execute pulse
        if (execRise) begin
            if (st.ctrl[CTL_TRACE]) begin
                if (traceSetupBad) begin
                    setEv[ST_TRERR] = 1'b1;
                end else begin
                    next_st.traceStart = 1'b1;
                    setEv[ST_TRACE] = 1'b1;
                end
            end
            if (st.ctrl[CTL_XTRACE]) begin
                if (extTraceSetupBad) begin
                    setEv[ST_TRERR] = 1'b1;
                end else begin
                    next_st.extTraceStart = 1'b1;
                    setEv[ST_XTRACE] = 1'b1;
                end
            end
            if (st.ctrl[CTL_RUN]) begin
                if (runBlocked) begin
                    setEv[ST_RUNFAIL] = 1'b1;
                end else begin
                    next_st.runStart = 1'b1;
                    setEv[ST_RUN] = 1'b1;
                end
            end
        end
        // Status: a new event wins over the read clear
        next_st.status = (st.status & ~clrEv) | setEv;
        next_st.breakReq = !monitorActive && (st.breakReq || trig);
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{ctrl: CTL_RST, route: RT_RST, status: ST_RST, mask: MASK_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign breakReq = st.breakReq;
    assign traceStart = st.traceStart;
    assign extTraceStart = st.extTraceStart;
    assign runStart = st.runStart;
    assign irq = st.irq;

    // --------------------------------------------------
    // Checks
    // --------------------------------------------------
    sequence s_execRun;
        execRise && st.ctrl[CTL_RUN];
    endsequence
    sequence s_execTrace;
        execRise && st.ctrl[CTL_TRACE];
    endsequence
    sequence s_coordEnable;
        regWr && regAddr == BTL_CTRL && regWrData[CTL_COORD] && !st.ctrl[CTL_COORD];
    endsequence

    property p_coaxEdge;
        @(posedge mclk) disable iff (!rst_b)
        st.ctrl[CTL_COAX] && coaxS && !st.coaxPrev |=> st.status[ST_COAX];
    endproperty
    a_coaxEdge: assert property (p_coaxEdge) else $error("coaxial edge not latched");

    property p_coaxHold;
        @(posedge mclk) disable iff (!rst_b)
        st.status[ST_COAX] && !rdStat |=> st.status[ST_COAX];
    endproperty
    a_coaxHold: assert property (p_coaxHold) else $error("coaxial event lost before read");

    property p_coordBreak;
        @(posedge mclk) disable iff (!rst_b)
        st.ctrl[CTL_COORD] && coordS && !monitorActive |=> breakReq;
    endproperty
    a_coordBreak: assert property (p_coordBreak) else $error("coordination trigger gave no break");

    property p_coordEnable;
        @(posedge mclk) disable iff (!rst_b)
        s_coordEnable ##1 (st.ctrl[CTL_COORD] && coordS) |=> st.status[ST_COORD];
    endproperty
    a_coordEnable: assert property (p_coordEnable) else $error("true coordination line not reported");

    property p_coordRerun;
        @(posedge mclk) disable iff (!rst_b)
        st.ctrl[CTL_COORD] && coordS && st.sentCoord && st.monPrev && !monitorActive |=> breakReq && !st.sentCoord;
    endproperty
    a_coordRerun: assert property (p_coordRerun) else $error("no break back after run");

    property p_coordOnce;
        @(posedge mclk) disable iff (!rst_b)
        st.sentCoord && !st.status[ST_COORD] && monitorActive == st.monPrev |=> !st.status[ST_COORD];
    endproperty
    a_coordOnce: assert property (p_coordOnce) else $error("coordination event reported twice");

    property p_oneEnableClear;
        @(posedge mclk) disable iff (!rst_b)
        regWr && regAddr == BTL_CTRL && regWrData[CTL_ONE] && !st.ctrl[CTL_ONE] |=> !st.status[ST_ONE];
    endproperty
    a_oneEnableClear: assert property (p_oneEnableClear) else $error("old line one event kept");

    logic lineOnce1;
    logic lineOnce2;
    assign lineOnce1 = st.route[RT_COORD] && coordS;
    assign lineOnce2 = st.route[RT_LINE_W + RT_COORD] && coordS;

    property p_oneRepeat;
        @(posedge mclk) disable iff (!rst_b)
        st.ctrl[CTL_ONE] && lineS[0] && !lineOnce1 |=> st.status[ST_ONE];
    endproperty
    a_oneRepeat: assert property (p_oneRepeat) else $error("line one event not re-set");

    property p_oneOnce;
        @(posedge mclk) disable iff (!rst_b)
        lineOnce1 && st.sentLine[0] && !st.status[ST_ONE] && monitorActive == st.monPrev |=> !st.status[ST_ONE];
    endproperty
    a_oneOnce: assert property (p_oneOnce) else $error("line one event reported twice");

    property p_twoRepeat;
        @(posedge mclk) disable iff (!rst_b)
        st.ctrl[CTL_ONE + 1] && lineS[1] && !lineOnce2 |=> st.status[ST_TWO];
    endproperty
    a_twoRepeat: assert property (p_twoRepeat) else $error("line two event not re-set");

    property p_traceStart;
        @(posedge mclk) disable iff (!rst_b)
        s_execTrace and !traceSetupBad |=> traceStart && st.status[ST_TRACE] ##1 !traceStart;
    endproperty
    a_traceStart: assert property (p_traceStart) else $error("trace start missing");

    property p_xtraceStart;
        @(posedge mclk) disable iff (!rst_b)
        execRise && st.ctrl[CTL_XTRACE] && !extTraceSetupBad |=> extTraceStart && st.status[ST_XTRACE];
    endproperty
    a_xtraceStart: assert property (p_xtraceStart) else $error("external trace start missing");

    property p_runStart;
        @(posedge mclk) disable iff (!rst_b)
        s_execRun and !runBlocked |=> runStart && st.status[ST_RUN];
    endproperty
    a_runStart: assert property (p_runStart) else $error("run start missing");

    property p_runFail;
        @(posedge mclk) disable iff (!rst_b)
        s_execRun and runBlocked |=> st.status[ST_RUNFAIL] && !runStart;
    endproperty
    a_runFail: assert property (p_runFail) else $error("run failure not flagged");

    property p_traceErr;
        @(posedge mclk) disable iff (!rst_b)
        s_execTrace and traceSetupBad |=> st.status[ST_TRERR] && !traceStart;
    endproperty
    a_traceErr: assert property (p_traceErr) else $error("trace error not flagged");

    property p_clash;
        @(posedge mclk) disable iff (!rst_b)
        regWr && regAddr == BTL_ROUTE && routeClash(regWrData[RT_LINE_W-1:0])
        |=> st.status[ST_CONF] && st.route[RT_LINE_W-1:0] == $past(st.route[RT_LINE_W-1:0]);
    endproperty
    a_clash: assert property (p_clash) else $error("clashing route accepted");

    property p_runHold;
        @(posedge mclk) disable iff (!rst_b)
        st.status[ST_RUN] && !rdStat |=> st.status[ST_RUN];
    endproperty
    a_runHold: assert property (p_runHold) else $error("run event lost before read");
endmodule // btl_break_trigger

// >>> tb/btl_core_model.sv
`timescale 1ns/100ps
module btl_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Requests from the block and the bench
    input wire logic breakReq,
    input wire logic runStart,
    input wire logic runReq,
    input wire logic slowMode,
    // Core state
    output logic monitorActive
);
    logic [3:0] waitCnt;
    // ----------------------------------------
    // Enters the monitor after a break request, leaves on any run
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            monitorActive <= 1'b0;
            waitCnt <= 4'h0;
        end else if (runStart || runReq) begin
            monitorActive <= 1'b0;
            waitCnt <= 4'h0;
        end else if (breakReq && !monitorActive) begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt >= (slowMode ? 4'h6 : 4'h1)) begin
                monitorActive <= 1'b1;
            end
        end else begin
            waitCnt <= 4'h0;
        end
    end
endmodule // btl_core_model

// >>> tb/btl_break_trigger_tb.sv
`timescale 1ns/100ps
module btl_break_trigger_tb;
    import btl_pkg::*;
    logic mclk, rst_b, regWr, regRd, coax, coordTrig, coordExec, trigOne, trigTwo;
    logic monActive, runBlocked, trBad, xtrBad, breakReq, trStart, xtrStart, runStart, irq, runReq, slowMode;
    logic [BTL_AW-1:0] regAddr;
    logic [BTL_DW-1:0] regWrData, regRdData, d;
    logic [15:0] seed;
    int n_fail, checked, np;
    btl_break_trigger dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .coaxialTriggerConnector(coax),
        .coordTrigger(coordTrig), .coordExecute(coordExec), .internalTriggerOne(trigOne),
        .internalTriggerTwo(trigTwo), .monitorActive(monActive), .runBlocked(runBlocked),
        .traceSetupBad(trBad), .extTraceSetupBad(xtrBad), .breakReq(breakReq), .traceStart(trStart),
        .extTraceStart(xtrStart), .runStart(runStart), .irq(irq));
    btl_core_model core (.mclk(mclk), .rst_b(rst_b), .breakReq(breakReq), .runStart(runStart),
        .runReq(runReq), .slowMode(slowMode), .monitorActive(monActive));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [BTL_DW-1:0] execExp(input logic rb, input logic tb, input logic xb);
        return ((32'(!tb) << ST_TRACE) | (32'(!xb) << ST_XTRACE) | (32'(!rb) << ST_RUN)
            | (32'(rb) << ST_RUNFAIL) | (32'(tb | xb) << ST_TRERR));
    endfunction
    task automatic give_verdict();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [BTL_AW-1:0] a, input logic [BTL_DW-1:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [BTL_AW-1:0] a, output logic [BTL_DW-1:0] v);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic waitFor(input int which);
        #1;
        for (int i = 0; i < 200; i++) begin
            if (which == 0 && breakReq === 1'b1) return;
            if (which == 1 && monActive === 1'b1) return;
            @(posedge mclk);
            #1;
        end
        n_fail++;
        give_verdict();
    endtask
    task automatic pulseRun();
        @(posedge mclk);
        runReq <= 1'b1;
        @(posedge mclk);
        runReq <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic execPulse(output int n);
        n = 0;
        @(posedge mclk);
        coordExec <= 1'b1;
        repeat (2) @(posedge mclk);
        coordExec <= 1'b0;
        repeat (8) begin
            @(posedge mclk);
            #1 n += int'(trStart) + int'(xtrStart) + int'(runStart);
        end
    endtask
    // ----------------------------------------
    // Clock, reset and watchdog
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        give_verdict();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_b, regWr, regRd, coax, coordTrig, coordExec, trigOne, trigTwo} = '0;
        {runBlocked, trBad, xtrBad, runReq, slowMode} = '0;
        regAddr = '0;
        regWrData = '0;
        seed = 16'd4906;
        n_fail = 0;
        checked = 0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            rd((k == 5) ? 8'h20 : 8'(4 * k), d);
            chk(d, 32'h0);
        end
        repeat (4) begin
            seed = lfsr(seed);
            wr(BTL_MASK, {21'h0, seed[10:0]});
            rd(BTL_MASK, d);
            chk(d, {21'h0, seed[10:0]});
        end
        wr(BTL_MASK, 32'h0);
        // Coaxial edge, then a second edge while in the monitor
        slowMode <= seed[0];
        wr(BTL_CTRL, 32'h1 << CTL_COAX);
        coax <= 1'b1;
        waitFor(0);
        chk(breakReq, 1'b1);
        chk(irq, 1'b0);
        waitFor(1);
        repeat (3) @(posedge mclk);
        rd(BTL_STATE, d);
        chk(d, 32'h3);
        rd(BTL_STATUS, d);
        chk(d, 32'h1 << ST_COAX);
        rd(BTL_STATUS, d);
        chk(d, 32'h0);
        coax <= 1'b0;
        repeat (4) @(posedge mclk);
        coax <= 1'b1;
        repeat (5) @(posedge mclk);
        rd(BTL_STATUS, d);
        chk(d, 32'h1 << ST_COAX);
        wr(BTL_CTRL, 32'h0);
        pulseRun();
        // Coordination trigger already true at enable
        coordTrig <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(BTL_CTRL, 32'h1 << CTL_COORD);
        waitFor(0);
        chk(breakReq, 1'b1);
        waitFor(1);
        repeat (4) @(posedge mclk);
        rd(BTL_STATUS, d);
        chk(d, 32'h1 << ST_COORD);
        rd(BTL_STATUS, d);
        chk(d, 32'h0);
        pulseRun();
        waitFor(0);
        chk(breakReq, 1'b1);
        waitFor(1);
        coordTrig <= 1'b0;
        wr(BTL_CTRL, 32'h0);
        rd(BTL_STATUS, d);
        // Trigger lines, internal source then coordination source
        for (int i = 0; i < 2; i++) begin
            wr(BTL_ROUTE, 32'h0);
            pulseRun();
            trigOne <= (i == 0);
            trigTwo <= (i == 1);
            repeat (4) @(posedge mclk);
            wr(BTL_CTRL, 32'h1 << (CTL_ONE + i));
            waitFor(0);
            chk(breakReq, 1'b1);
            waitFor(1);
            repeat (3) @(posedge mclk);
            rd(BTL_STATUS, d);
            chk(d, 32'h1 << (ST_ONE + i));
            rd(BTL_STATUS, d);
            chk(d, 32'h1 << (ST_ONE + i));
            wr(BTL_ROUTE, 32'h10 << (RT_LINE_W * i));
            coordTrig <= 1'b1;
            repeat (4) @(posedge mclk);
            wr(BTL_CTRL, 32'h0);
            wr(BTL_CTRL, 32'h1 << (CTL_ONE + i));
            repeat (6) @(posedge mclk);
            rd(BTL_STATUS, d);
            chk(d, 32'h1 << (ST_ONE + i));
            rd(BTL_STATUS, d);
            chk(d, 32'h0);
            coordTrig <= 1'b0;
            repeat (5) @(posedge mclk);
            rd(BTL_STATUS, d);
            chk(d, 32'h1 << (ST_ONE + i));
            {trigOne, trigTwo} <= 2'b00;
            wr(BTL_CTRL, 32'h0);
            repeat (4) @(posedge mclk);
            rd(BTL_STATUS, d);
        end
        // Execute pulse, clean and with failures
        wr(BTL_ROUTE, 32'h0);
        wr(BTL_CTRL, (32'h1 << CTL_TRACE) | (32'h1 << CTL_XTRACE) | (32'h1 << CTL_RUN));
        rd(BTL_STATUS, d);
        for (int c = 0; c < 3; c++) begin
            runBlocked <= (c == 1);
            trBad <= (c == 1);
            xtrBad <= (c == 2);
            execPulse(np);
            chk(32'(np), 32'(3 - 2 * (c == 1) - (c == 2)));
            rd(BTL_STATUS, d);
            chk(d, execExp(c == 1, c == 1, c == 2));
            chk(d[ST_RUNFAIL], (c == 1));
            chk(d[ST_TRERR], (c != 0));
        end
        {runBlocked, trBad, xtrBad} <= 3'b000;
        // Clashing route groups, interrupt and read clear
        wr(BTL_CTRL, 32'h0);
        wr(BTL_MASK, (32'h1 << ST_CONF) | (32'h1 << (ST_CONF + 1)));
        for (int i = 0; i < 2; i++) begin
            wr(BTL_ROUTE, ((i == 0) ? 32'h3 : 32'hc) << (RT_LINE_W * i));
            repeat (2) @(posedge mclk);
            #1 chk(irq, 1'b1);
            rd(BTL_ROUTE, d);
            chk(d, 32'h0);
            rd(BTL_STATUS, d);
            chk(d, 32'h1 << (ST_CONF + i));
            chk(irq, 1'b0);
        end
        give_verdict();
    end
endmodule // btl_break_trigger_tb
